// [core/pin_edge_detect.v]
// Edge detector for a synchronous pin input
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Pin level and edge pulses
  input wire pin,
  output wire rise,
  output wire fall
);
  reg prev_q;

  // Previous level, idle high so reset does not fake a rising edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= pin;
    end
  end

  assign rise = pin & ~prev_q;
  assign fall = ~pin & prev_q;
endmodule // pin_edge_detect
`default_nettype wire

// [core/pwm_and_pulse_measure_timers.v]
// Modulation timer and capture timer with a plain register port
`timescale 1ns/1ps
`default_nettype none
`include "pwm_capture_defs.vh"
module pwm_and_pulse_measure_timers #(
  parameter DW = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [DW-1:0] reg_rdata,
  // Pins
  input wire timer_a_input_pin,
  output reg timer_a_output_pin,
  input wire timer_b_input_pin,
  // Request pulses
  output reg timer_a_req,
  output reg timer_b_req
);
  // Overview of the modulation timer (A side)
  //   Mode pattern 111 in the low bits selects modulation; anything else halts it.
  //   While halted, a data write loads the reload register and the counter.
  //   The start bit arms the modulator; with external start it then waits
  //   for the chosen edge on the trigger pin, and ignores every later edge.
  //   Once running, nothing but clearing the start bit or the mode stops it.
  //   The first modulator tick after the start only lines the waveform up
  //   with the count clock, so every high time is a whole number of ticks.
  //   The phase counter then counts one full period of ticks, and the width
  //   counter counts down the high time; at the period end the reload value
  //   is copied into the width counter, so a new width shows from the next rise.
  //   In 8-bit form the low byte is a prescaler and the high byte the width,
  //   which trades resolution for a much shorter period.
  //
  // Overview of the capture timer (B side)
  //   Timer mode counts count-clock ticks down; event mode counts pin edges.
  //   At zero the counter reloads and a one-cycle request pulse is raised.
  //   Measurement mode counts ticks up between qualifying pin edges and
  //   copies the count into the reload register, which reads back as result.
  //   The first capture after the start only opens the interval, so it
  //   raises no request; its value is not a full period or width.
  //   A count that wraps past all ones sets the overflow flag, which only a
  //   mode register write clears.
  //
  // Limitations
  //   Pins are taken as synchronous; a pin pulse shorter than one clock can
  //   be lost, and a level must stand two count clocks in measurement.
  //   All count clocks come from one shared divider, so both timers tick
  //   on the same edges when they select the same source.
  //   Reading the modulation data returns zero while mode 111 is set, since its value is undefined; other modes read the reload register.
  reg [7:0] a_mode_q;
  reg [7:0] b_mode_q;
  reg b_ovf_q;
  reg [DW-1:0] a_reload_q;
  reg [DW-1:0] a_cnt_q;
  reg [DW-1:0] a_phase_q;
  reg [7:0] a_pre_q;
  reg a_run_q;
  reg a_live_q;
  reg [DW-1:0] b_reload_q;
  reg [DW-1:0] b_cnt_q;
  reg b_first_q;
  reg a_start_q;
  reg b_start_q;
  reg a_reqbit_q;
  reg b_reqbit_q;
  reg [`DIV_W-1:0] div_q;
  wire a_rise;
  wire a_fall;
  wire b_rise;
  wire b_fall;

  // Pin edge detectors
  pin_edge_detect a_edges (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin(timer_a_input_pin),
    .rise(a_rise),
    .fall(a_fall)
  );

  pin_edge_detect b_edges (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin(timer_b_input_pin),
    .rise(b_rise),
    .fall(b_fall)
  );

  // Write decodes
  wire wr_a_mode = reg_wr && (reg_addr == `OFS_A_MODE);
  wire wr_a_data = reg_wr && (reg_addr == `OFS_A_DATA);
  wire wr_b_mode = reg_wr && (reg_addr == `OFS_B_MODE);
  wire wr_b_data = reg_wr && (reg_addr == `OFS_B_DATA);
  wire wr_start = reg_wr && (reg_addr == `OFS_START);
  wire wr_req = reg_wr && (reg_addr == `OFS_REQ);

  // Shared free-running divider for the count clock sources
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= {`DIV_W{1'b0}};
    end else begin
      div_q <= div_q + {{(`DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // Tick when the low bits of the divider are all ones
  function tick_of;
    input [1:0] sel;
    input [`DIV_W-1:0] div;
    reg [`DIV_W-1:0] mask;
    begin
      mask = {`DIV_W{1'b0}};
      case (sel)
        2'h0: mask = (9'h001 << `DIV_SHIFT0) - 9'h001;
        2'h1: mask = (9'h001 << `DIV_SHIFT1) - 9'h001;
        2'h2: mask = (9'h001 << `DIV_SHIFT2) - 9'h001;
        default: mask = (9'h001 << `DIV_SHIFT3) - 9'h001;
      endcase
      tick_of = ((div & mask) == mask);
    end
  endfunction

  wire a_tick = tick_of(a_mode_q[7:`BIT_SRC_LO], div_q);
  wire b_tick = tick_of(b_mode_q[7:`BIT_SRC_LO], div_q);

  // Mode decodes for the modulation timer
  wire a_pwm = (a_mode_q[2:0] == `A_MODE_PWM);
  wire a_len8 = a_mode_q[`BIT_LEN8];
  wire a_ext = a_mode_q[`BIT_EXT];
  wire a_trig_edge = a_mode_q[`BIT_EDGE3] ? a_rise : a_fall;
  wire a_go = a_start_q && a_pwm && (!a_ext || a_trig_edge);

  // 8-bit form: prescaler pulse paces the modulator
  wire a_pre_pulse = a_tick && (a_pre_q == 8'h00);
  wire a_mtick = a_len8 ? a_pre_pulse : a_tick;
  wire [DW-1:0] a_last = a_len8 ? `PWM_LAST8 : `PWM_LAST16;
  wire [DW-1:0] a_width = a_len8 ? {8'h00, a_reload_q[15:8]} : a_reload_q;

  // Modulation timer state
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      a_reload_q <= `RST_DATA;
      a_cnt_q <= `RST_DATA;
      a_phase_q <= `RST_DATA;
      a_pre_q <= 8'h00;
      a_run_q <= 1'b0;
      a_live_q <= 1'b0;
    end else begin
      if (wr_a_data) begin
        a_reload_q <= reg_wdata;
      end
      if (!a_start_q || !a_pwm) begin
        // Halted: data writes reach counter as well
        a_run_q <= 1'b0;
        a_live_q <= 1'b0;
        a_phase_q <= `RST_DATA;
        if (wr_a_data) begin
          a_cnt_q <= a_len8 ? {8'h00, reg_wdata[15:8]} : reg_wdata;
          a_pre_q <= reg_wdata[7:0];
        end
      end else if (!a_run_q) begin
        // Waiting for the trigger; triggers only matter here
        if (a_go) begin
          a_run_q <= 1'b1;
          a_live_q <= 1'b0;
          a_phase_q <= `RST_DATA;
        end
      end else begin
        if (a_len8 && a_tick) begin
          a_pre_q <= (a_pre_q == 8'h00) ? a_reload_q[7:0] : a_pre_q - 8'h01;
        end
        if (a_mtick) begin
          if (!a_live_q) begin
            // First tick aligns the output to the count clock; no count yet
            a_live_q <= 1'b1;
          end else if (a_phase_q == a_last) begin
            // End of period: fresh width just before the rise
            a_phase_q <= `RST_DATA;
            a_cnt_q <= a_width;
          end else begin
            a_phase_q <= a_phase_q + 16'h0001;
            if (a_cnt_q != 16'h0000) begin
              a_cnt_q <= a_cnt_q - 16'h0001;
            end
          end
        end
      end
    end
  end

  // High while running and width remains; falling edge raises a request
  wire a_out_d = a_run_q && a_live_q && (a_cnt_q != 16'h0000) && a_start_q && a_pwm;
  wire a_fall_out = timer_a_output_pin && !a_out_d;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer_a_output_pin <= 1'b0;
      timer_a_req <= 1'b0;
    end else begin
      timer_a_output_pin <= a_out_d;
      timer_a_req <= a_fall_out && a_run_q;
    end
  end

  // Capture timer decodes
  wire [1:0] b_sel = b_mode_q[1:0];
  wire b_e3 = b_mode_q[`BIT_EDGE3];
  wire b_e2 = b_mode_q[`BIT_EDGE2];
  wire b_meas = (b_sel == `B_MODE_MEAS);
  // Event edges: 00 fall, 01 rise, 10 both
  wire b_evt = b_e3 ? (b_rise | b_fall) : (b_e2 ? b_rise : b_fall);
  // Measurement edges: period picks one edge, width takes either
  wire b_cap_edge = b_e3 ? (b_rise | b_fall) : (b_e2 ? b_rise : b_fall);
  wire b_dec = (b_sel == `B_MODE_EVENT) ? b_evt : b_tick;
  wire b_cap = b_start_q && b_meas && b_cap_edge;
  wire b_wrap = b_start_q && b_meas && !b_cap && b_tick && (b_cnt_q == 16'hFFFF);
  wire b_zero = b_start_q && !b_meas && (b_sel != 2'h3) && b_dec && (b_cnt_q == 16'h0000);

  // Capture timer counter and reload register
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      b_reload_q <= `RST_DATA;
      b_cnt_q <= `RST_DATA;
      b_first_q <= 1'b1;
      timer_b_req <= 1'b0;
    end else begin
      timer_b_req <= 1'b0;
      if (!b_start_q) begin
        b_first_q <= 1'b1;
        if (wr_b_data) begin
          b_reload_q <= reg_wdata;
          b_cnt_q <= reg_wdata;
        end
      end else if (b_meas) begin
        if (b_cap) begin
          b_reload_q <= b_cnt_q;
          b_cnt_q <= `RST_DATA;
          b_first_q <= 1'b0;
          timer_b_req <= !b_first_q;
        end else if (b_tick) begin
          b_cnt_q <= b_cnt_q + 16'h0001;
        end
      end else if (b_sel != 2'h3) begin
        if (wr_b_data) begin
          b_reload_q <= reg_wdata;
        end
        if (b_dec) begin
          if (b_cnt_q == 16'h0000) begin
            b_cnt_q <= wr_b_data ? reg_wdata : b_reload_q;
            timer_b_req <= 1'b1;
          end else begin
            b_cnt_q <= b_cnt_q - 16'h0001;
          end
        end
      end
    end
  end

  // Mode registers; overflow flag set wins over the clearing write
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      a_mode_q <= `RST_A_MODE;
      b_mode_q <= `RST_B_MODE;
      b_ovf_q <= 1'b1;
    end else begin
      if (wr_a_mode) begin
        a_mode_q <= reg_wdata[7:0];
      end
      if (wr_b_mode) begin
        b_mode_q <= reg_wdata[7:0];
      end
      if (b_wrap) begin
        b_ovf_q <= 1'b1;
      end else if (wr_b_mode) begin
        b_ovf_q <= 1'b0;
      end
    end
  end

  // Start bits and sticky request bits (write one to clear, set wins)
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      a_start_q <= 1'b0;
      b_start_q <= 1'b0;
      a_reqbit_q <= 1'b0;
      b_reqbit_q <= 1'b0;
    end else begin
      if (wr_start) begin
        a_start_q <= reg_wdata[0];
        b_start_q <= reg_wdata[1];
      end
      if (timer_a_req) begin
        a_reqbit_q <= 1'b1;
      end else if (wr_req && reg_wdata[0]) begin
        a_reqbit_q <= 1'b0;
      end
      if (timer_b_req) begin
        b_reqbit_q <= 1'b1;
      end else if (wr_req && reg_wdata[1]) begin
        b_reqbit_q <= 1'b0;
      end
    end
  end

  // Read data, registered one cycle after the strobe
  reg [DW-1:0] rd_d;
  always @* begin
    rd_d = {DW{1'b0}};
    if (reg_addr == `OFS_A_MODE) begin
      rd_d = {8'h00, a_mode_q};
    end else if (reg_addr == `OFS_A_DATA) begin
      rd_d = a_pwm ? {DW{1'b0}} : a_reload_q;
    end else if (reg_addr == `OFS_B_MODE) begin
      rd_d = {8'h00, b_mode_q[7:6], b_ovf_q, b_mode_q[4:0]};
    end else if (reg_addr == `OFS_B_DATA) begin
      rd_d = b_meas ? b_reload_q : b_cnt_q;
    end else if (reg_addr == `OFS_START) begin
      rd_d = {14'h0000, b_start_q, a_start_q};
    end else if (reg_addr == `OFS_REQ) begin
      rd_d = {14'h0000, b_reqbit_q, a_reqbit_q};
    end
  end

  // Read data holds only in the cycle after the strobe
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= {DW{1'b0}};
    end else begin
      reg_rdata <= reg_rd ? rd_d : {DW{1'b0}};
    end
  end
endmodule // pwm_and_pulse_measure_timers
`default_nettype wire

// [core/pwm_capture_defs.vh]
// Constants for the modulation timer and the capture timer
`ifndef PWM_CAPTURE_DEFS_VH
`define PWM_CAPTURE_DEFS_VH
// Register indices on the plain register port
`define OFS_A_MODE 4'h0
`define OFS_A_DATA 4'h1
`define OFS_B_MODE 4'h2
`define OFS_B_DATA 4'h3
`define OFS_START 4'h4
`define OFS_REQ 4'h5
// Mode field positions
`define BIT_SRC_LO 6
`define BIT_LEN8 5
`define BIT_OVF 5
`define BIT_EXT 4
`define BIT_EDGE3 3
`define BIT_EDGE2 2
// Mode patterns
`define A_MODE_PWM 3'h7
`define B_MODE_TIMER 2'h0
`define B_MODE_EVENT 2'h1
`define B_MODE_MEAS 2'h2
// Reset values
`define RST_A_MODE 8'h00
`define RST_B_MODE 8'h20
`define RST_DATA 16'h0000
// Modulation period end counts (2^16-1 and 2^8-1 periods)
`define PWM_LAST16 16'hFFFE
`define PWM_LAST8 16'h00FE
// Count clock divider shifts for source select 0..3
`define DIV_SHIFT0 1
`define DIV_SHIFT1 4
`define DIV_SHIFT2 6
`define DIV_SHIFT3 9
`define DIV_W 9
`endif

// [test/pin_source.sv]
// Model of the trigger source and the measured pulse source
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // Clock
  input wire logic clk_sys,
  // Driven pins, idle high
  output logic timer_a_input_pin,
  output logic timer_b_input_pin
);
  // Both pins start high; pin b returns high after each pulse train, pin a keeps the level set_a last drove
  initial begin
    timer_a_input_pin = 1'b1;
    timer_b_input_pin = 1'b1;
  end
  // Held a few cycles so two triggers never merge in the edge detector
  task automatic set_a(input logic lvl);
    @(posedge clk_sys);
    timer_a_input_pin <= lvl;
    repeat (4) @(posedge clk_sys);
  endtask
  // Low then high pulses; callers keep each level two count clocks or more
  task automatic pulses_b(input int n, input int lo, input int hi);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      timer_b_input_pin <= 1'b0;
      repeat (lo) @(posedge clk_sys);
      timer_b_input_pin <= 1'b1;
      repeat (hi - 1) @(posedge clk_sys);
    end
  endtask
endmodule // pin_source
`default_nettype wire

// [test/pwm_timers_monitor.sv]
// Port checker for the modulation and capture timers
`timescale 1ns/1ps
`default_nettype none
`include "pwm_capture_defs.vh"
module pwm_timers_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Modulator pin and requests
  input wire logic timer_a_output_pin,
  input wire logic timer_a_req,
  input wire logic timer_b_req
);
  logic [7:0] a_mode_q;
  logic [1:0] start_q;
  logic b_wr_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Shadow of software writes, since the checks see only ports
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      a_mode_q <= 8'h00;
      start_q <= 2'h0;
      b_wr_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_A_MODE) a_mode_q <= reg_wdata[7:0];
      if (reg_addr == `OFS_START) start_q <= reg_wdata[1:0];
      if (reg_addr == `OFS_B_MODE) b_wr_q <= 1'b1;
    end
  end
  idle_read_zero_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_read_blank_a:
    assert property (reg_rd && reg_addr == `OFS_A_DATA && a_mode_q[2:0] == 3'h7 |=> reg_rdata == 16'h0000)
    else $error("modulator data read not blank");
  ovf_reset_one_a:
    assert property (reg_rd && reg_addr == `OFS_B_MODE && !b_wr_q |=> reg_rdata[5])
    else $error("overflow flag lost before mode write");
  mode_high_zero_a: assert property (reg_rd && reg_addr == `OFS_B_MODE |=> reg_rdata[15:8] == 8'h00)
    else $error("mode upper byte not zero");
  a_req_fall_a: assert property (start_q[0] && $fell(timer_a_output_pin) |-> ##[0:2] timer_a_req)
    else $error("no request at output fall");
  a_req_once_a: assert property (timer_a_req |=> !timer_a_req)
    else $error("modulator request longer than one cycle");
  a_idle_low_a: assert property (!start_q[0] && !timer_a_output_pin |=> !timer_a_output_pin)
    else $error("modulator output rose while stopped");
  b_idle_quiet_a: assert property ((!start_q[1]) [*2] |=> !timer_b_req)
    else $error("capture request while stopped");
endmodule // pwm_timers_monitor
bind pwm_and_pulse_measure_timers pwm_timers_monitor mon (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .timer_a_output_pin, .timer_a_req, .timer_b_req);
`default_nettype wire

// [test/testbench.sv]
// Directed bench for the modulation and capture timers
`timescale 1ns/1ps
`default_nettype none
`include "pwm_capture_defs.vh"
module testbench;
  logic clk_sys, reset_n, reg_wr, reg_rd, a_in, a_out, b_in, a_req, b_req;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v1;
  logic [15:0] ev_mode [3] = '{16'h0001, 16'h0005, 16'h0009};
  logic [15:0] ev_exp [3] = '{16'h0002, 16'h0002, 16'h0004};
  logic [15:0] ms_mode [3] = '{16'h0002, 16'h0006, 16'h000A};
  logic [15:0] ms_exp [3] = '{16'h0002, 16'h0002, 16'h0005};
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int nb = 0;
  int t0, s, c0;
  pwm_and_pulse_measure_timers uut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_a_input_pin(a_in), .timer_a_output_pin(a_out), .timer_b_input_pin(b_in),
    .timer_a_req(a_req), .timer_b_req(b_req));
  pin_source src (.clk_sys, .timer_a_input_pin(a_in), .timer_b_input_pin(b_in));
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Cycle stamp and count of capture requests
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (b_req === 1'b1) nb <= nb + 1;
  end
  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] v, input logic [15:0] e);
    check_count++;
    if (v !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, v, e);
    end
  endtask
  // One-cycle strobes, changed just after an edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v1 = reg_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    check(v1, e);
  endtask
  // Bounded wait: 0 output high, 1 output low, 2 capture request
  task automatic wait_on(input int w);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      if (w == 0 ? a_out === 1'b1 : w == 1 ? a_out === 1'b0 : b_req === 1'b1) break;
    end
    t0 = cyc;
    if (i == 3000) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic hi_time;
    wait_on(0);
    s = t0;
    wait_on(1);
  endtask
  // Main sequence; count clock is the divide-by-2 source throughout
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc(`OFS_A_MODE, 16'h0000);
    rdc(`OFS_B_MODE, 16'h0020);
    rdc(4'hB, 16'h0000);
    wr(`OFS_A_DATA, 16'h0003);
    wr(`OFS_A_MODE, 16'h0007);
    rdc(`OFS_A_DATA, 16'h0000);
    wr(`OFS_START, 16'h0001);
    hi_time();
    check(16'(t0 - s), 16'h0006);
    wr(`OFS_START, 16'h0000);
    wr(`OFS_A_DATA, 16'h0201);
    wr(`OFS_A_MODE, 16'h0027);
    wr(`OFS_START, 16'h0001);
    hi_time();
    hi_time();
    check(16'(t0 - s), 16'h0008);
    wr(`OFS_A_DATA, 16'h0301);
    wait_on(0);
    check(16'(t0 - s), 16'h03FC);
    s = t0;
    wait_on(1);
    check(16'(t0 - s), 16'h000C);
    // External start on each edge kind; later triggers must not restart the period
    for (int j = 0; j < 2; j++) begin
      wr(`OFS_START, 16'h0000);
      src.set_a(!j[0]);
      wr(`OFS_A_MODE, j ? 16'h003F : 16'h0037);
      wr(`OFS_START, 16'h0001);
      repeat (12) @(posedge clk_sys);
      check({15'h0000, a_out}, 16'h0000);
      src.set_a(j[0]);
      hi_time();
      src.set_a(!j[0]);
      src.set_a(j[0]);
      wait_on(0);
      check(16'(t0 - s), 16'h03FC);
    end
    wr(`OFS_START, 16'h0000);
    wr(`OFS_B_MODE, 16'h0000);
    rdc(`OFS_B_MODE, 16'h0000);
    wr(`OFS_B_DATA, 16'h0004);
    wr(`OFS_START, 16'h0002);
    wait_on(2);
    s = t0;
    wait_on(2);
    check(16'(t0 - s), 16'h000A);
    wr(`OFS_B_DATA, 16'h0007);
    wait_on(2);
    s = t0;
    wait_on(2);
    check(16'(t0 - s), 16'h0010);
    // Event counting: three counted edges per request from a reload of 2
    for (int j = 0; j < 3; j++) begin
      wr(`OFS_START, 16'h0000);
      wr(`OFS_B_MODE, ev_mode[j]);
      wr(`OFS_B_DATA, 16'h0002);
      wr(`OFS_START, 16'h0002);
      c0 = nb;
      src.pulses_b(6, 4, 4);
      repeat (6) @(posedge clk_sys);
      check(16'(nb - c0), ev_exp[j]);
    end
    // Measurement: compare two captures so the edge-to-clear latency cancels
    for (int j = 0; j < 3; j++) begin
      wr(`OFS_START, 16'h0000);
      wr(`OFS_B_MODE, ms_mode[j]);
      wr(`OFS_START, 16'h0002);
      c0 = nb;
      src.pulses_b(3, 8, 8);
      repeat (4) @(posedge clk_sys);
      check(16'(nb - c0), ms_exp[j]);
      rd(`OFS_B_DATA);
      s = v1;
      src.pulses_b(3, j == 2 ? 24 : 16, j == 2 ? 8 : 16);
      rd(`OFS_B_DATA);
      check(16'(v1 - s), 16'h0008);
    end
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
